/* File: verilog/ctseq_regs.vh */
`ifndef CTSEQ_REGS_VH
`define CTSEQ_REGS_VH
// Register byte offsets on the Wishbone bus.
`define CTSEQ_CTRL_ADDR      8'h00
`define CTSEQ_PERIOD_ADDR    8'h04
`define CTSEQ_DURATION_ADDR  8'h08
`define CTSEQ_TONE_ADDR      8'h0C
`define CTSEQ_COUNT_ADDR     8'h10
`define CTSEQ_CLIP_ADDR      8'h14
`define CTSEQ_STATUS_ADDR    8'h18
`define CTSEQ_SCHED_ADDR     8'h1C
// Control register fields.
`define CTSEQ_CTRL_START     0
`define CTSEQ_CTRL_CLIP_MODE 1
`define CTSEQ_CTRL_STRAP_PRI 2
`define CTSEQ_CTRL_DAUGHTERBOARD_POWER_SELECT    3
`define CTSEQ_CTRL_SCHED_EN  4
// Status register fields.
`define CTSEQ_STAT_BUSY      0
`define CTSEQ_STAT_DONE      1
// Reset values.
`define CTSEQ_PERIOD_RST     32'h0000_0000
`define CTSEQ_DURATION_RST   32'h0000_0000
`define CTSEQ_TONE_RST       16'h0000
`define CTSEQ_COUNT_RST      16'h0000
// Timing: one second at 125 MHz, and the minute boundary.
`define CTSEQ_CLK_HZ         125000000
`define CTSEQ_SEC_SECONDS    1
`define CTSEQ_SCHED_SECONDS  60
// Identification timeout in clock cycles, used when the sender never answers.
`define CTSEQ_ID_CYCLES      32'h0000_1000
`endif

/* File: verilog/ctseq_top.v */
// Summary of operation
// - Carrier on with audio, then silence, repeatedly.
// - Period, duration, tone, count settings drive chirps.
// - Clip mode: duration delays audio, clip sets length.
// - Begin step powers RF, then sends identification.
// - End step identifies, then shuts RF down.
// - Timer square tone, tristated when silent.
// - Push-to-talk asserted only while transmitting.
// - Primary strap: power enable removed between chirps.
// - Daughterboard flag: per-chirp separate power switch.
// - Time-of-year clock starts schedule on minute.
//
// The implementer's own choices: the Wishbone interface to the registers and the placing of the registers.
`timescale 1ns/10ps
`default_nettype none
`include "ctseq_regs.vh"
////////////////////////////////////////////////////////////////////////////////
// How a message runs.
// Software loads the period, duration, tone, count and clip registers first.
// A write of the start bit, or a schedule hit, then raises a pending request.
// The request is taken only in the idle state, so a second request made
// while a message is running waits and starts the next message afterwards.
// The begin step keys the radio and asks the identification sender to run.
// It waits for the sender's done pulse, or for the identification timeout,
// so a missing sender can never hang the sequencer for good.
// Each chirp then keys carrier and audio for the duration setting.
// In clip mode the duration is an idle carrier delay and the clip length
// gives the audio time instead.
// The period is counted from the start of each chirp; the quiet part of the
// chirp lasts until the period has run out.
// A period shorter than the active time leaves a single quiet cycle only, which the
// user must avoid; the hardware does not stretch it.
// After the configured number of chirps the end step identifies again and
// drops the radio, and the done flag is raised for software to poll.
// A count of zero runs the two identification steps with no chirp between.
// All times are given in clock cycles, so a loaded value of N means that
// the interval lasts N cycles (the tone half-period N+1); a loaded zero lasts a single cycle.
// The time-of-year seconds counter wraps every minute; the schedule fires
// on the configured second of each minute, independent of power-on order.
// The radio outputs come straight from flip-flops, so each one trails the
// state register by one clock cycle, except the timer tone, which passes through tone_lvl and trails it by two.
////////////////////////////////////////////////////////////////////////////////
module ctseq_top #(
	parameter [31:0] SEC_CYCLES = `CTSEQ_CLK_HZ / `CTSEQ_SEC_SECONDS,
	parameter [31:0] ID_CYCLES  = `CTSEQ_ID_CYCLES
) (
	// Clock and reset.
	input  wire        mclk,
	input  wire        rst_n,
	// Wishbone classic slave.
	input  wire        wb_cyc_i,
	input  wire        wb_stb_i,
	input  wire        wb_we_i,
	input  wire [7:0]  wb_adr_i,
	input  wire [3:0]  wb_sel_i,
	input  wire [31:0] wb_dat_i,
	output reg  [31:0] wb_dat_o,
	output reg         wb_ack_o,
	// Stored audio clip source.
	input  wire        clip_bit,
	output reg         clip_play,
	// Identification sender handshake.
	input  wire        ident_done,
	output reg         ident_start,
	// Radio side.
	output reg         tone_square_wave,
	output reg         tone_oe_n,
	output reg         ptt,
	output reg         transmit_power_enable,
	output reg         daughterboard_power_select
);
	localparam [6:0] S_IDLE   = 7'h01;
	localparam [6:0] S_BID    = 7'h02;
	localparam [6:0] S_DELAY  = 7'h04;
	localparam [6:0] S_ON     = 7'h08;
	localparam [6:0] S_QUIET  = 7'h10;
	localparam [6:0] S_EID    = 7'h20;
	localparam [6:0] S_FINISH = 7'h40;

	// Registers written by software, and the done flag set by the sequencer.
	reg [4:0]  ctrl;
	reg [31:0] period;
	reg [31:0] duration;
	reg [15:0] tone_half;
	reg [15:0] count;
	reg [31:0] clip_len;
	reg [5:0]  sched_sec;
	reg        done_flag;
	// Sequencer state.
	reg [6:0]  state;
	reg [31:0] timer;
	reg [31:0] phase;
	reg [15:0] loops;
	reg [15:0] tone_cnt;
	reg        tone_lvl;
	reg [31:0] sec_cnt;
	reg [5:0]  toy_sec;
	reg        start_req;

	wire wb_hit = wb_cyc_i & wb_stb_i & ~wb_ack_o;
	wire wb_wr  = wb_hit & wb_we_i & (&wb_sel_i);
	wire busy   = (state != S_IDLE);
	wire radio_on = (state == S_DELAY) | (state == S_ON);
	wire audio_on = (state == S_ON);

	function [31:0] sat_dec;
		input [31:0] v;
		begin
			sat_dec = (v == 32'h0000_0000) ? 32'h0000_0000 : v - 32'h0000_0001;
		end
	endfunction

	////////////////////////////////////////////////////////////////////////////
	// Bus slave; partial-byte writes are ignored, unmapped reads return zero.
	always @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			wb_ack_o  <= 1'b0;
			wb_dat_o  <= 32'h0000_0000;
			ctrl      <= 5'h00;
			period    <= `CTSEQ_PERIOD_RST;
			duration  <= `CTSEQ_DURATION_RST;
			tone_half <= `CTSEQ_TONE_RST;
			count     <= `CTSEQ_COUNT_RST;
			clip_len  <= 32'h0000_0000;
			sched_sec <= 6'h00;
		end else begin
			wb_ack_o <= wb_hit;
			ctrl[`CTSEQ_CTRL_START] <= 1'b0;
			if (wb_wr) begin
				case (wb_adr_i)
					`CTSEQ_CTRL_ADDR:     ctrl      <= wb_dat_i[4:0];
					`CTSEQ_PERIOD_ADDR:   period    <= wb_dat_i;
					`CTSEQ_DURATION_ADDR: duration  <= wb_dat_i;
					`CTSEQ_TONE_ADDR:     tone_half <= wb_dat_i[15:0];
					`CTSEQ_COUNT_ADDR:    count     <= wb_dat_i[15:0];
					`CTSEQ_CLIP_ADDR:     clip_len  <= wb_dat_i;
					`CTSEQ_SCHED_ADDR:    sched_sec <= wb_dat_i[5:0];
					default: ;
				endcase
			end
			case (wb_adr_i)
				`CTSEQ_CTRL_ADDR:     wb_dat_o <= {27'h0, ctrl};
				`CTSEQ_PERIOD_ADDR:   wb_dat_o <= period;
				`CTSEQ_DURATION_ADDR: wb_dat_o <= duration;
				`CTSEQ_TONE_ADDR:     wb_dat_o <= {16'h0, tone_half};
				`CTSEQ_COUNT_ADDR:    wb_dat_o <= {16'h0, count};
				`CTSEQ_CLIP_ADDR:     wb_dat_o <= clip_len;
				`CTSEQ_STATUS_ADDR:   wb_dat_o <= {loops, 8'h0, toy_sec[5:0], done_flag, busy};
				`CTSEQ_SCHED_ADDR:    wb_dat_o <= {26'h0, sched_sec};
				default:              wb_dat_o <= 32'h0000_0000;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Time-of-year seconds; a schedule fires on the configured second each minute.
	always @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			sec_cnt   <= 32'h0000_0000;
			toy_sec   <= 6'h00;
			start_req <= 1'b0;
		end else begin
			// The idle sequencer takes a pending request on this edge.
			// The clear comes first so a set in the same cycle wins over it.
			if (state == S_IDLE && start_req)
				start_req <= 1'b0;
			if (sec_cnt >= SEC_CYCLES - 32'h0000_0001) begin
				sec_cnt <= 32'h0000_0000;
				toy_sec <= (toy_sec == 6'd59) ? 6'h00 : toy_sec + 6'h01;
				if (ctrl[`CTSEQ_CTRL_SCHED_EN] &&
				    ((toy_sec == 6'd59) ? 6'h00 : toy_sec + 6'h01) == sched_sec)
					start_req <= 1'b1;
			end else begin
				sec_cnt <= sec_cnt + 32'h0000_0001;
			end
			// A request made while busy waits for the idle state.
			if (ctrl[`CTSEQ_CTRL_START])
				start_req <= 1'b1;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Step sequencer: begin identification, chirp loops, end identification.
	// Software must bound count and period so identification recurs in time.
	always @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			state       <= S_IDLE;
			timer       <= 32'h0000_0000;
			phase       <= 32'h0000_0000;
			loops       <= 16'h0000;
			ident_start <= 1'b0;
			done_flag   <= 1'b0;
		end else begin
			ident_start <= 1'b0;
			timer <= sat_dec(timer);
			phase <= sat_dec(phase);
			case (state)
				S_IDLE: begin
					if (start_req) begin
						state       <= S_BID;
						ident_start <= 1'b1;
						loops       <= 16'h0000;
						done_flag   <= 1'b0;
						timer       <= ID_CYCLES;
					end
				end
				S_BID: begin
					if (ident_done || timer == 32'h0000_0000) begin
						if (count == 16'h0000) begin
							state       <= S_EID;
							ident_start <= 1'b1;
							timer       <= ID_CYCLES;
						end else begin
							// Timers count down to zero inclusive, hence one less.
							state <= ctrl[`CTSEQ_CTRL_CLIP_MODE] ? S_DELAY : S_ON;
							phase <= sat_dec(period);
							timer <= sat_dec(duration);
						end
					end
				end
				S_DELAY: begin
					if (timer == 32'h0000_0000) begin
						state <= S_ON;
						timer <= sat_dec(clip_len);
					end
				end
				S_ON: begin
					if (timer == 32'h0000_0000)
						state <= S_QUIET;
				end
				S_QUIET: begin
					if (phase == 32'h0000_0000) begin
						if (loops + 16'h0001 >= count) begin
							state       <= S_EID;
							ident_start <= 1'b1;
							timer       <= ID_CYCLES;
						end else begin
							state <= ctrl[`CTSEQ_CTRL_CLIP_MODE] ? S_DELAY : S_ON;
							phase <= sat_dec(period);
							timer <= sat_dec(duration);
						end
						loops <= loops + 16'h0001;
					end
				end
				S_EID: begin
					if (ident_done || timer == 32'h0000_0000)
						state <= S_FINISH;
				end
				S_FINISH: begin
					state     <= S_IDLE;
					done_flag <= 1'b1;
				end
				default: state <= S_IDLE;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Tone generator and radio pins; all registered so outputs come off flops.
	always @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			tone_cnt                   <= 16'h0000;
			tone_lvl                   <= 1'b0;
			tone_square_wave           <= 1'b0;
			tone_oe_n                  <= 1'b1;
			ptt                        <= 1'b0;
			transmit_power_enable      <= 1'b0;
			daughterboard_power_select <= 1'b0;
			clip_play                  <= 1'b0;
		end else begin
			if (!audio_on || tone_cnt == 16'h0000) begin
				tone_cnt <= tone_half;
				tone_lvl <= audio_on & ~tone_lvl;
			end else begin
				tone_cnt <= tone_cnt - 16'h0001;
			end
			if (ctrl[`CTSEQ_CTRL_CLIP_MODE]) begin
				tone_square_wave <= clip_bit;
				clip_play        <= audio_on;
			end else begin
				tone_square_wave <= tone_lvl;
				clip_play        <= 1'b0;
			end
			// Identification also needs the radio keyed, so begin and end count.
			tone_oe_n <= ~audio_on;
			ptt <= radio_on | (state == S_BID) | (state == S_EID);
			// Primary strap drops power between chirps; otherwise it holds for the message.
			transmit_power_enable <= ctrl[`CTSEQ_CTRL_STRAP_PRI] ?
				(radio_on | state == S_BID | state == S_EID) : busy;
			daughterboard_power_select <= ctrl[`CTSEQ_CTRL_DAUGHTERBOARD_POWER_SELECT] & radio_on;
		end
	end
endmodule // ctseq_top
`default_nettype wire

/* File: sim/ctseq_chk_assertions.sv */
`timescale 1ns/10ps
`default_nettype none
// Watches bus timing and radio keying of the sequencer top.
module ctseq_chk (
	// Clock, reset and bus.
	input wire logic mclk, rst_n, wb_cyc_i, wb_stb_i, wb_ack_o,
	// Radio side.
	input wire logic clip_play, ident_start, tone_oe_n, ptt, transmit_power_enable
);
	default clocking @(posedge mclk); endclocking
	default disable iff (!rst_n);
	// A burst ends when the tone driver lets go of the line.
	sequence s_burst_end; $rose(tone_oe_n); endsequence
	// Quiet must last at least two cycles, so the tone never runs straight into the next burst.
	sequence s_quiet; tone_oe_n [*2]; endsequence
	a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack held too long");
	a_ack_cause: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i)) else $error("ack without request");
	a_ident_pulse: assert property (ident_start |=> !ident_start) else $error("ident start not a pulse");
	a_ident_keyed: assert property (ident_start |=> ptt) else $error("identifying unkeyed");
	a_tone_quiet: assert property (!ptt |-> tone_oe_n) else $error("tone driven while unkeyed");
	a_burst_power: assert property ($fell(tone_oe_n) |-> ptt && transmit_power_enable) else $error("burst unpowered");
	a_burst_gap: assert property (s_burst_end |-> s_quiet) else $error("no quiet after burst");
	a_clip_keyed: assert property (clip_play |-> ptt) else $error("clip plays unkeyed");
endmodule // ctseq_chk
bind ctseq_top ctseq_chk u_chk (.mclk(mclk), .rst_n(rst_n), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
	.wb_ack_o(wb_ack_o), .clip_play(clip_play), .ident_start(ident_start), .tone_oe_n(tone_oe_n),
	.ptt(ptt), .transmit_power_enable(transmit_power_enable));
`default_nettype wire

/* File: sim/ctseq_radio_model.sv */
`timescale 1ns/10ps
`default_nettype none
// Identification sender and clip store standing beside the sequencer.
module ctseq_radio_model (
	// Clock, inputs from the sequencer, and the delay set by the testbench.
	input  wire logic       mclk, ident_start, clip_play,
	input  wire logic [7:0] id_delay,
	// Answers.
	output var  logic       ident_done = 1'b0,
	output var  logic       clip_bit = 1'b0
);
	logic [7:0] wait_cnt = 8'h00;
	logic       sending = 1'b0;
	// Identification takes id_delay + 1 cycles; the clip level changes every cycle so a stale level never looks right.
	always @(posedge mclk) begin
		ident_done <= 1'b0;
		clip_bit <= ~clip_bit;
		if (ident_start) begin
			sending <= 1'b1;
			wait_cnt <= id_delay;
		end else if (sending) begin
			if (wait_cnt == 8'h00) begin
				sending <= 1'b0;
				ident_done <= 1'b1;
			end else wait_cnt <= wait_cnt - 8'h01;
		end
	end
endmodule // ctseq_radio_model
`default_nettype wire

/* File: sim/chirp_transmit_sequencer_tb.sv */
`timescale 1ns/10ps
`default_nettype none
`include "ctseq_regs.vh"
module chirp_transmit_sequencer_tb;
	logic        mclk = 1'b0, rst_n = 1'b0, cyc = 1'b0, stb = 1'b0, we = 1'b0, ack;
	logic        clip_bit, clip_play, ident_done, ident_start, tone, oe_n, ptt, pwr, dbp;
	logic [7:0]  adr = 8'h00, id_dly = 8'h10;
	logic [31:0] dat = 32'h0, rdat, q;
	integer      err_total = 0, n_checks = 0, seed = 32'h4667C9A7, cyc_n = 0, ids, pw_up, db_up, len, k;
	integer      lens[$];
	always #4 mclk = ~mclk;
	ctseq_top #(.SEC_CYCLES(32'h14), .ID_CYCLES(32'h40)) dut (.mclk(mclk), .rst_n(rst_n), .wb_cyc_i(cyc),
		.wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(dat), .wb_dat_o(rdat),
		.wb_ack_o(ack), .clip_bit(clip_bit), .clip_play(clip_play), .ident_done(ident_done),
		.ident_start(ident_start), .tone_square_wave(tone), .tone_oe_n(oe_n), .ptt(ptt),
		.transmit_power_enable(pwr), .daughterboard_power_select(dbp));
	ctseq_radio_model radio (.mclk(mclk), .ident_start(ident_start), .clip_play(clip_play),
		.id_delay(id_dly), .ident_done(ident_done), .clip_bit(clip_bit));
	////////////////////////////////////////////////////////////////////////////
	// Burst lengths, identifications and power switching are recorded for the checks in run.
	always @(posedge mclk) begin
		cyc_n = cyc_n + 1;
		if (cyc_n == 60000) begin
			err_total = err_total + 1;
			complete_run;
		end
		if (oe_n === 1'b0) len = len + 1;
		else if (len > 0) begin
			lens.push_back(len);
			len = 0;
		end
		if (ident_start === 1'b1) ids = ids + 1;
	end
	always @(posedge pwr) pw_up = pw_up + 1;
	always @(posedge dbp) db_up = db_up + 1;
	task complete_run;
		begin
			$display("checks=%0d errors=%0d", n_checks, err_total);
			if (err_total == 0 && n_checks > 0) $display("Result: passed");
			else $display("Result: failed");
			$finish;
		end
	endtask
	task chk(input [31:0] got, input [31:0] exp);
		begin
			n_checks = n_checks + 1;
			if (got !== exp) begin
				err_total = err_total + 1;
				$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
			end
		end
	endtask
	// Classic single cycle; the request holds until ack is seen high.
	task wb(input [7:0] a, input [31:0] d, input w);
		begin
			@(posedge mclk);
			cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; dat <= d;
			do @(posedge mclk); while (ack !== 1'b1);
			q = rdat;
			cyc <= 1'b0; stb <= 1'b0; we <= 1'b0;
		end
	endtask
	// Counts stay small so identification comes round often.
	task run(input [31:0] ctrl, input [15:0] cnt, input [31:0] dur, input [31:0] clen);
		begin
			lens.delete(); ids = 0; pw_up = 0; db_up = 0; len = 0;
			wb(`CTSEQ_PERIOD_ADDR, dur + clen + 32'h10, 1'b1);
			wb(`CTSEQ_DURATION_ADDR, dur, 1'b1);
			wb(`CTSEQ_TONE_ADDR, 32'h3, 1'b1);
			wb(`CTSEQ_COUNT_ADDR, {16'h0, cnt}, 1'b1);
			wb(`CTSEQ_CLIP_ADDR, clen, 1'b1);
			wb(`CTSEQ_CTRL_ADDR, ctrl | 32'h1, 1'b1);
			do wb(`CTSEQ_STATUS_ADDR, 32'h0, 1'b0); while (q[0] !== 1'b0 || q[1] !== 1'b1);
			chk(lens.size(), cnt);
			chk(ids, 2);
			foreach (lens[i]) chk(lens[i], ctrl[1] ? clen : dur);
			chk(q[31:16], cnt);
			if (ctrl[2]) chk(pw_up, cnt + 1);
			if (ctrl[3]) chk(db_up, cnt);
		end
	endtask
	////////////////////////////////////////////////////////////////////////////
	// Main sequence.
	initial begin
		repeat (6) @(posedge mclk);
		rst_n <= 1'b1;
		wb(`CTSEQ_PERIOD_ADDR, 32'h0, 1'b0);
		chk(q, `CTSEQ_PERIOD_RST);
		wb(8'h40, 32'h0, 1'b0);
		chk(q, 32'h0);
		run(32'h4, 16'h3, 32'h4 + ($random(seed) & 7), 32'h0);
		id_dly <= 8'h02;
		run(32'hA, 16'h2, 32'h5, 32'h6 + ($random(seed) & 7));
		run(32'h4, 16'h0, 32'h4, 32'h0);
		wb(`CTSEQ_SCHED_ADDR, 32'h0, 1'b1);
		wb(`CTSEQ_CTRL_ADDR, 32'h14, 1'b1);
		k = 0;
		while (ptt !== 1'b1 && k < 1300) begin
			@(posedge mclk);
			k = k + 1;
		end
		chk(ptt, 1'b1);
		wb(`CTSEQ_STATUS_ADDR, 32'h0, 1'b0);
		chk(q[7:2], 32'h0);
		complete_run;
	end
endmodule // chirp_transmit_sequencer_tb
`default_nettype wire
